// *** design/ddc_pkg.sv ***
// Shared constants and types for the DRAM CKE power-state tracker.
package ddc_pkg;
	localparam int unsigned APB_AW        = 8;
	localparam logic [7:0]  OFF_CTRL      = 8'h00;
	localparam logic [7:0]  OFF_STATUS    = 8'h04;
	localparam logic [7:0]  OFF_FLAGS     = 8'h08;
	localparam logic [7:0]  OFF_COUNT     = 8'h0C;
	localparam int unsigned CTRL_CHK_BIT  = 0;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
	localparam int unsigned NFLAGS        = 7;
	localparam int unsigned FL_CMD_EDGE   = 0;
	localparam int unsigned FL_HOLD       = 1;
	localparam int unsigned FL_XS_CMD     = 2;
	localparam int unsigned FL_BUSY_ENTRY = 3;
	localparam int unsigned FL_SREF_BANK  = 4;
	localparam int unsigned FL_PD_LONG    = 5;
	localparam int unsigned FL_RESET_EVT  = 6;
	localparam int unsigned TCK_NS        = 100;
	localparam int unsigned CKE_MIN_CYC   = 3;
	localparam int unsigned XSRD_CYC      = 200;
	localparam int unsigned XSNR_NS       = 1000;
	localparam int unsigned XSNR_CYC      = (XSNR_NS + TCK_NS - 1) / TCK_NS;
	localparam int unsigned MRD_CYC       = 2;
	localparam int unsigned BURST_CYC     = 4;
	localparam int unsigned CNT_W         = 16;
	localparam int unsigned BUSY_W        = 8;
	localparam int unsigned WR_LSB        = 9;
	localparam int unsigned SLOW_EXIT_BIT = 12;
	localparam int unsigned RTT_BIT_A     = 2;
	localparam int unsigned RTT_BIT_B     = 6;
	localparam logic [1:0]  BA_MR         = 2'h0;
	localparam logic [1:0]  BA_EMR        = 2'h1;
	localparam logic [2:0]  WR_CODE_BIAS  = 3'h1;
	localparam int unsigned BANKS         = 4;
	typedef enum logic [2:0] {ST_IDLE, ST_ACTIVE, ST_PPD, ST_APD, ST_SREF, ST_SREF_EXIT, ST_RESET} ddc_state_t;
endpackage : ddc_pkg

// *** design/ddc_sat_counter.sv ***
// Saturating cycle counter with synchronous clear and clock enable.
`timescale 1ns/10ps
module ddc_sat_counter #(
	parameter int unsigned W = 16
) (
	// Clock and control.
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic         clear,
	// Count value.
	output logic [W-1:0]      count
);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	assign count_next = clear ? '0 : ((&count_reg) ? count_reg : count_reg + 1'b1);
	always_ff @(posedge clk) begin
		if (rst)
			count_reg <= '0;
		else if (ce)
			count_reg <= count_next;
	end
	assign count = count_reg;
endmodule : ddc_sat_counter

// *** design/ddc_cke_tracker.sv ***
// CKE power-state tracker of a four-bank DDR2 device with an APB status port.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
//Function
// - CKE low with NOP/REF enters powerdown/selfrefresh.
// - No refresh in power-down; duration bounded.
// - Termination off in self refresh.
// - Write autoprecharge: entry after write recovery.
// - Reset ignores all but CKE; burst may finish.
module ddc_cke_tracker
	import ddc_pkg::*;
#(
	parameter int unsigned PD_MAX_CYC = 702
) (
	// Clock, reset, clock enable.
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      ce,
	// DRAM command pins from the controller.
	input  wire logic                      cke,
	input  wire logic                      csN,
	input  wire logic                      rasN,
	input  wire logic                      casN,
	input  wire logic                      weN,
	input  wire logic                      odt,
	input  wire logic [1:0]                ba,
	input  wire logic [12:0]               addr,
	// APB slave.
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [ddc_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Device state.
	output logic                           odtOn,
	output logic                           selfRefreshOn,
	output logic                           powerDownOn,
	output logic                           readOk
);
	localparam int unsigned PW = 21;
	logic [PW-1:0] pinMeta_reg, pinSync_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
		end else if (ce) begin
			pinMeta_reg <= {cke, csN, rasN, casN, weN, odt, ba, addr};
			pinSync_reg <= pinMeta_reg;
		end
	end
	wire        ckeS, csS, odtS;
	wire [2:0]  rcw;
	wire [1:0]  baS;
	wire [12:0] adS;
	assign {ckeS, csS, rcw, odtS, baS, adS} = pinSync_reg;
	wire        a10  = adS[10];
	wire        cmdNop   = csS | (rcw == 3'h7);
	wire        cmdAct   = !csS && rcw == 3'h3;
	wire        cmdRead  = !csS && rcw == 3'h5;
	wire        cmdWrite = !csS && rcw == 3'h4;
	wire        cmdPre   = !csS && rcw == 3'h2;
	wire        cmdRef   = !csS && rcw == 3'h1;
	wire        cmdLm    = !csS && rcw == 3'h0;

	ddc_state_t         state_reg, state_next;
	logic               ckeP_reg;
	logic [BANKS-1:0]   banks_reg, banks_next, banksCmd;
	logic [BUSY_W-1:0]  busy_reg, busy_next;
	logic [2:0]         wrCode_reg;
	logic               slowExit_reg, rttOn_reg, initPending_reg, chkEn_reg;
	logic [NFLAGS-1:0]  flags_reg, setMask, clrMask;
	logic [CNT_W-1:0]   stateCnt, holdCnt;
	logic [31:0]        prdata_reg, rdMux;
	logic               pready_reg, pslverr_reg, odtOn_reg, sref_reg, pd_reg, readOk_reg;

	wire ckeFall  = ckeP_reg && !ckeS;
	wire ckeRise  = !ckeP_reg && ckeS;
	wire cmdLive  = ckeP_reg && ckeS && state_reg != ST_RESET && !cmdNop;
	wire allIdle  = banks_reg == '0;
	wire busyNow  = busy_reg != '0;
	wire [BUSY_W-1:0] wrCyc = BUSY_W'(wrCode_reg + WR_CODE_BIAS);
	wire inPd     = state_reg == ST_PPD || state_reg == ST_APD;
	wire inExit   = state_reg == ST_SREF_EXIT;
	wire earlyRd  = inExit && cmdLive && cmdRead && stateCnt < CNT_W'(XSRD_CYC);
	wire earlyCmd = inExit && cmdLive && stateCnt < CNT_W'(XSNR_CYC);
	wire resetHit = ckeFall && (busyNow || !(cmdNop || (cmdRef && allIdle)));

	// Entry decode shared by idle, active and post-self-refresh states.
	ddc_state_t entryState;
	assign entryState = resetHit ? ST_RESET :
	                    cmdRef ? ST_SREF :
	                    allIdle ? ST_PPD : ST_APD;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE, ST_ACTIVE: begin
				if (ckeFall)
					state_next = entryState;
				else
					state_next = (banksCmd == '0) ? ST_IDLE : ST_ACTIVE;
			end
			ST_PPD, ST_APD: begin
				if (ckeRise)
					state_next = allIdle ? ST_IDLE : ST_ACTIVE;
			end
			ST_SREF: begin
				if (ckeRise)
					state_next = ST_SREF_EXIT;
			end
			ST_SREF_EXIT: begin
				if (ckeFall && stateCnt >= CNT_W'(XSNR_CYC))
					state_next = entryState;
				else if (ckeFall)
					state_next = ST_RESET;
				else if (stateCnt >= CNT_W'(XSRD_CYC - 1))
					state_next = (banksCmd == '0) ? ST_IDLE : ST_ACTIVE;
			end
			ST_RESET: begin
				if (ckeRise)
					state_next = ST_IDLE;
			end
			default: state_next = ST_RESET;
		endcase
	end

	// Bank tracking; auto precharge closes the bank with the access.
	always_comb begin
		banksCmd = banks_reg;
		if (cmdLive && cmdAct)
			banksCmd[baS] = 1'b1;
		else if (cmdLive && cmdPre)
			banksCmd = a10 ? '0 : (banks_reg & ~(BANKS'(1) << baS));
		else if (cmdLive && (cmdRead || cmdWrite) && a10)
			banksCmd[baS] = 1'b0;
	end
	assign banks_next = (state_next == ST_RESET) ? '0 : banksCmd;

	// Busy time covers bursts, write recovery and tMRD; REF/ACT/PRE add none.
	always_comb begin
		busy_next = busy_reg;
		if (cmdLive && cmdRead)
			busy_next = BUSY_W'(BURST_CYC);
		else if (cmdLive && cmdWrite)
			busy_next = BUSY_W'(BURST_CYC) + wrCyc;
		else if (cmdLive && cmdLm)
			busy_next = BUSY_W'(MRD_CYC);
		else if (busyNow && ckeS)
			busy_next = busy_reg - 1'b1;
	end

	assign setMask[FL_CMD_EDGE]   = (ckeFall || ckeRise) && !cmdNop && state_reg != ST_RESET
	                                && !(ckeFall && cmdRef);
	assign setMask[FL_HOLD]       = (ckeFall || ckeRise) && holdCnt < CNT_W'(CKE_MIN_CYC - 1);
	assign setMask[FL_XS_CMD]     = earlyRd || earlyCmd;
	assign setMask[FL_BUSY_ENTRY] = ckeFall && busyNow;
	assign setMask[FL_SREF_BANK]  = ckeFall && cmdRef && !allIdle;
	assign setMask[FL_PD_LONG]    = inPd && stateCnt >= CNT_W'(PD_MAX_CYC);
	assign setMask[FL_RESET_EVT]  = state_next == ST_RESET && state_reg != ST_RESET;

	wire apbAcc   = psel && penable && pready_reg;
	wire flagWr   = apbAcc && pwrite && paddr == OFF_FLAGS;
	wire addrOk   = paddr == OFF_CTRL || paddr == OFF_STATUS || paddr == OFF_FLAGS || paddr == OFF_COUNT;
	assign clrMask = flagWr ? pwdata[NFLAGS-1:0] : '0;
	assign rdMux  = paddr == OFF_CTRL   ? {31'h0, chkEn_reg} :
	                paddr == OFF_STATUS ? {19'h0, initPending_reg, rttOn_reg, slowExit_reg, wrCode_reg,
	                                       banks_reg, state_reg} :
	                paddr == OFF_FLAGS  ? {25'h0, flags_reg} :
	                paddr == OFF_COUNT  ? {16'h0, stateCnt} : 32'h0;

	ddc_sat_counter #(.W(CNT_W)) uStateCnt (
		.clk(clk), .rst(rst), .ce(ce), .clear(state_next != state_reg), .count(stateCnt));
	ddc_sat_counter #(.W(CNT_W)) uHoldCnt (
		.clk(clk), .rst(rst), .ce(ce), .clear(ckeS != ckeP_reg), .count(holdCnt));

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg  <= ST_RESET;
			ckeP_reg   <= 1'b0;
			banks_reg  <= '0;
			busy_reg   <= '0;
			flags_reg  <= '0;
		end else if (ce) begin
			state_reg  <= state_next;
			ckeP_reg   <= ckeS;
			banks_reg  <= banks_next;
			busy_reg   <= busy_next;
			flags_reg  <= (flags_reg & ~clrMask) | (chkEn_reg ? setMask : '0);
		end
	end

	// Mode register capture; a LOAD MODE also ends the need to initialize.
	always_ff @(posedge clk) begin
		if (rst) begin
			wrCode_reg      <= '0;
			slowExit_reg    <= 1'b0;
			rttOn_reg       <= 1'b0;
			initPending_reg <= 1'b1;
		end else if (ce) begin
			if (state_next == ST_RESET)
				initPending_reg <= 1'b1;
			else if (cmdLive && cmdLm)
				initPending_reg <= 1'b0;
			if (cmdLive && cmdLm && baS == BA_MR) begin
				wrCode_reg   <= adS[WR_LSB +: 3];
				slowExit_reg <= adS[SLOW_EXIT_BIT];
			end
			if (cmdLive && cmdLm && baS == BA_EMR)
				rttOn_reg <= adS[RTT_BIT_A] | adS[RTT_BIT_B];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			chkEn_reg   <= CTRL_RESET[CTRL_CHK_BIT];
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= '0;
		end else if (ce) begin
			pready_reg <= psel && penable && !pready_reg;
			if (psel && penable && !pready_reg) begin
				pslverr_reg <= !addrOk;
				prdata_reg  <= pwrite ? 32'h0 : rdMux;
			end
			if (apbAcc && pwrite && paddr == OFF_CTRL)
				chkEn_reg <= pwdata[CTRL_CHK_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			odtOn_reg  <= 1'b0;
			sref_reg   <= 1'b0;
			pd_reg     <= 1'b0;
			readOk_reg <= 1'b0;
		end else if (ce) begin
			odtOn_reg  <= rttOn_reg && odtS && state_next != ST_SREF && state_next != ST_RESET;
			sref_reg   <= state_next == ST_SREF;
			pd_reg     <= state_next == ST_PPD || state_next == ST_APD;
			readOk_reg <= state_next == ST_IDLE || state_next == ST_ACTIVE;
		end
	end

	assign prdata        = prdata_reg;
	assign pready        = pready_reg;
	assign pslverr       = pslverr_reg;
	assign odtOn         = odtOn_reg;
	assign selfRefreshOn = sref_reg;
	assign powerDownOn   = pd_reg;
	assign readOk        = readOk_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_sref_entry: assert property (ce && state_reg == ST_IDLE && ckeFall && cmdRef && !busyNow
		|=> state_reg == ST_SREF) else $error("self refresh entry missed");
	a_sref_odt_off: assert property (state_reg == ST_SREF |-> !odtOn_reg)
		else $error("termination on in self refresh");
	a_pd_exit_idle: assert property (ce && state_reg == ST_PPD && ckeS |=> state_reg == ST_IDLE)
		else $error("power-down exit missed");
	a_busy_reset: assert property (ce && state_reg == ST_ACTIVE && ckeFall && busyNow
		|=> state_reg == ST_RESET && (flags_reg[FL_RESET_EVT] || !$past(chkEn_reg))) else $error("reset not taken");
	a_pd_too_long: assert property (ce && chkEn_reg && state_reg == ST_PPD && stateCnt >= CNT_W'(PD_MAX_CYC)
		|=> flags_reg[FL_PD_LONG]) else $error("power-down limit not flagged");
	a_cke_hold: assert property (ce && chkEn_reg && ckeRise && holdCnt < CNT_W'(CKE_MIN_CYC - 1)
		|=> flags_reg[FL_HOLD]) else $error("short cke hold not flagged");
	a_early_read: assert property (ce && chkEn_reg && earlyRd |=> flags_reg[FL_XS_CMD])
		else $error("early read not flagged");
	a_wr_busy: assert property (ce && cmdLive && cmdWrite
		|=> busy_reg == BUSY_W'(BURST_CYC) + BUSY_W'($past(wrCode_reg) + WR_CODE_BIAS)) else $error("write busy wrong");
	a_flag_sticky: assert property (ce && !flagWr |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
		else $error("flag lost without clear");
	a_apb_ready: assert property (ce && psel && penable && !pready_reg |=> pready_reg)
		else $error("apb ready late");
	c_sref_enter: cover property (state_reg == ST_IDLE ##1 state_reg == ST_SREF);
	c_apd_enter: cover property (state_reg == ST_ACTIVE ##1 state_reg == ST_APD);
	c_reset_evt: cover property (state_reg == ST_ACTIVE ##1 state_reg == ST_RESET);
endmodule : ddc_cke_tracker

// *** test/ddc_ctl_model.sv ***
// Memory controller model that drives the DRAM command pins of the tracker.
`timescale 1ns/10ps
module ddc_ctl_model (
	// Clock.
	input  wire logic        clk,
	// DRAM command pins.
	output logic             cke,
	output logic             csN,
	output logic             rasN,
	output logic             casN,
	output logic             weN,
	output logic             odt,
	output logic [1:0]       ba,
	output logic [12:0]      addr
);
	initial begin
		cke = 1'b0;
		{csN, rasN, casN, weN} = 4'h7;
		odt = 1'b0;
		ba = 2'h0;
		addr = 13'h0000;
	end
	// One command for one cycle, then a NOP at the same CKE level; ODT is always driven.
	task automatic issue(input logic [3:0] c, input logic k, input logic [1:0] b, input logic [12:0] a,
			input logic o);
		@(posedge clk);
		cke <= k;
		{csN, rasN, casN, weN} <= c;
		odt <= o;
		ba <= b;
		addr <= a;
		@(posedge clk);
		{csN, rasN, casN, weN} <= 4'h7;
		ba <= ~b;
		addr <= ~a;
	endtask : issue
endmodule : ddc_ctl_model

// *** test/ddc_cke_tracker_bench.sv ***
// Self-checking bench for the CKE power-state tracker.
`timescale 1ns/10ps
module ddc_cke_tracker_bench;
	import ddc_pkg::*;
	localparam logic [3:0] C_NOP = 4'h7;
	localparam logic [3:0] C_ACT = 4'h3;
	localparam logic [3:0] C_RD  = 4'h5;
	localparam logic [3:0] C_PRE = 4'h2;
	localparam logic [3:0] C_REF = 4'h1;
	localparam logic [3:0] C_LM  = 4'h0;
	logic        clk, rst, cke, csN, rasN, casN, weN, odt;
	logic        psel, penable, pwrite, pready, pslverr, rdErr;
	logic        odtOn, selfRefreshOn, powerDownOn, readOk;
	logic [1:0]  ba;
	logic [12:0] addr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          num_errors = 0;
	int          n_tests = 0;
	ddc_ctl_model i_ctl (.clk(clk), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
		.odt(odt), .ba(ba), .addr(addr));
	ddc_cke_tracker #(.PD_MAX_CYC(20)) i_dut (.clk(clk), .rst(rst), .ce(1'b1), .cke(cke), .csN(csN),
		.rasN(rasN), .casN(casN), .weN(weN), .odt(odt), .ba(ba), .addr(addr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .odtOn(odtOn), .selfRefreshOn(selfRefreshOn),
		.powerDownOn(powerDownOn), .readOk(readOk));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One APB transfer; read data and error are taken at the edge where pready is seen.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k == 20) chk("pready", 32'h1, {31'h0, pready});
		rd = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic testReset;
		cyc(1);
		chk("outs", 32'h0, {28'h0, odtOn, selfRefreshOn, powerDownOn, readOk});
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("status", 32'h1006, rd & 32'h1007);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk("ctrl", CTRL_RESET, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h1, {rd[30:0], rdErr});
		i_ctl.issue(C_NOP, 1'b1, 2'h0, 13'h0000, 1'b0);
		cyc(5);
		chk("readOk", 32'h1, {31'h0, readOk});
	endtask : testReset
	task automatic testPowerDown;
		i_ctl.issue(C_NOP, 1'b0, 2'h0, 13'h0000, 1'b0);
		cyc(4);
		chk("powerDownOn", 32'h1, {31'h0, powerDownOn});
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("state", 32'h2, rd & 32'h7);
		cyc(24);
		i_ctl.issue(C_NOP, 1'b1, 2'h0, 13'h0000, 1'b0);
		cyc(4);
		chk("pdExit", 32'h1, {30'h0, powerDownOn, readOk});
		apb(1'b0, OFF_FLAGS, 32'h0);
		chk("flags", 32'h20, rd & 32'h23);
		apb(1'b1, OFF_FLAGS, 32'h7F);
		apb(1'b0, OFF_FLAGS, 32'h0);
		chk("cleared", 32'h0, rd);
	endtask : testPowerDown
	task automatic testHold;
		i_ctl.issue(C_NOP, 1'b0, 2'h0, 13'h0000, 1'b0);
		i_ctl.issue(C_NOP, 1'b1, 2'h0, 13'h0000, 1'b0);
		cyc(4);
		apb(1'b0, OFF_FLAGS, 32'h0);
		chk("holdFlag", 32'h2, rd & 32'h2);
		apb(1'b1, OFF_FLAGS, 32'h7F);
	endtask : testHold
	task automatic testReadBusy;
		i_ctl.issue(C_ACT, 1'b1, 2'h0, 13'h0000, 1'b0);
		i_ctl.issue(C_RD, 1'b1, 2'h0, 13'h0000, 1'b0);
		i_ctl.issue(C_NOP, 1'b0, 2'h0, 13'h0000, 1'b0);
		cyc(4);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("resetState", 32'h6, rd & 32'h7);
		apb(1'b0, OFF_FLAGS, 32'h0);
		chk("busyFlags", 32'h48, rd & 32'h48);
		i_ctl.issue(C_NOP, 1'b1, 2'h0, 13'h0000, 1'b0);
		cyc(4);
		apb(1'b1, OFF_FLAGS, 32'h7F);
		i_ctl.issue(C_ACT, 1'b1, 2'h1, 13'h0000, 1'b0);
		i_ctl.issue(C_RD, 1'b1, 2'h1, 13'h0000, 1'b0);
		cyc(BURST_CYC + 2);
		i_ctl.issue(C_NOP, 1'b0, 2'h0, 13'h0000, 1'b0);
		cyc(4);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("apd", 32'h13, rd & 32'h7F);
		apb(1'b0, OFF_FLAGS, 32'h0);
		chk("noFlags", 32'h0, rd & 32'h4B);
		i_ctl.issue(C_NOP, 1'b1, 2'h0, 13'h0000, 1'b0);
		i_ctl.issue(C_PRE, 1'b1, 2'h0, 13'h0400, 1'b0);
		cyc(2);
	endtask : testReadBusy
	task automatic testModeFreq;
		i_ctl.issue(C_LM, 1'b1, BA_MR, 13'h1600, 1'b0);
		cyc(MRD_CYC);
		i_ctl.issue(C_NOP, 1'b0, 2'h0, 13'h0000, 1'b0);
		cyc(4);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("modeReg", 32'h582, rd & 32'h787);
		apb(1'b0, OFF_FLAGS, 32'h0);
		chk("lmEntry", 32'h0, rd & 32'h48);
		apb(1'b0, OFF_COUNT, 32'h0);
		chk("stateCount", 32'hC, rd);
		i_ctl.issue(C_NOP, 1'b1, 2'h0, 13'h0000, 1'b0);
		i_ctl.issue(C_LM, 1'b1, BA_MR, 13'h0300, 1'b0);
		cyc(200);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("relockMode", 32'h80, rd & 32'h787);
	endtask : testModeFreq
	task automatic testSelfRefresh;
		i_ctl.issue(C_LM, 1'b1, BA_EMR, 13'h0004, 1'b0);
		cyc(4);
		i_ctl.issue(C_NOP, 1'b1, 2'h0, 13'h0000, 1'b1);
		cyc(4);
		chk("odtOn", 32'h1, {31'h0, odtOn});
		i_ctl.issue(C_REF, 1'b0, 2'h0, 13'h0000, 1'b1);
		cyc(4);
		chk("sref", 32'h2, {30'h0, selfRefreshOn, odtOn});
		cyc(2);
		i_ctl.issue(C_NOP, 1'b1, 2'h0, 13'h0000, 1'b0);
		i_ctl.issue(C_ACT, 1'b1, 2'h2, 13'h0000, 1'b0);
		cyc(20);
		i_ctl.issue(C_RD, 1'b1, 2'h2, 13'h0000, 1'b0);
		cyc(130);
		chk("exitWin", 32'h0, {31'h0, readOk});
		cyc(60);
		chk("relock", 32'h1, {31'h0, readOk});
		apb(1'b0, OFF_FLAGS, 32'h0);
		chk("xsFlag", 32'h4, rd & 32'h4);
	endtask : testSelfRefresh
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#(3000 * 100);
		num_errors++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		testReset();
		testPowerDown();
		testHold();
		testReadBusy();
		testModeFreq();
		testSelfRefresh();
		print_verdict();
	end
endmodule : ddc_cke_tracker_bench
